/* src/ssf_top.sv */
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ssf_regs.svh"
module ssf_top
  import ssf_pkg::*;
#(
  parameter int SAMPLE_HZ = `SSF_SAMPLE_HZ
) (
  input  wire logic               SYS_CLK,
  input  wire logic               RST,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [7:0]         PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire logic               SP_IN_VALID,
  input  wire logic signed [31:0] SP_IN_DATA,
  output logic                    SP_OUT_VALID,
  output logic signed [31:0]      SP_OUT_DATA
);

  // ----------------------------------------------------------------------
  // Constants and helpers
  // ----------------------------------------------------------------------
  localparam logic [63:0] A_MUL   = (`SSF_TWO_PI_Q16 << 20) / (64'(SAMPLE_HZ) * 64'd10);
  localparam logic [63:0] K1_NUM  = (`SSF_TC_UNITS_PER_S << 16) / 64'(SAMPLE_HZ);
  localparam logic [31:0] F_LIMIT = 32'(SAMPLE_HZ) * 32'd5;

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                        input logic [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [31:0] limit_write(input logic [3:0] idx, input logic [31:0] v);
    unique case (idx)
      4'h0:                         limit_write = {30'd0, v[1:0]};
      4'h1, 4'h7:                   limit_write = clamp(v, 32'd0, `SSF_MAX_TYPE);
      4'h2, 4'h8:                   limit_write = clamp(v, 32'd0, `SSF_MAX_TC);
      4'h3, 4'h5, 4'h9, 4'hB:       limit_write = clamp(v, `SSF_MIN_FREQ, `SSF_MAX_FREQ);
      4'h4, 4'hA:                   limit_write = clamp(v, `SSF_MIN_DDEN, `SSF_MAX_DAMP);
      default:                      limit_write = clamp(v, `SSF_MIN_DNUM, `SSF_MAX_DAMP);
    endcase
  endfunction

  function automatic logic [31:0] reset_value(input logic [3:0] idx);
    unique case (idx)
      4'h0:                         reset_value = `SSF_RST_ENABLE;
      4'h1, 4'h7:                   reset_value = `SSF_RST_TYPE;
      4'h2, 4'h8:                   reset_value = `SSF_RST_TC;
      4'h3, 4'h5, 4'h9, 4'hB:       reset_value = `SSF_RST_FREQ;
      default:                      reset_value = `SSF_RST_DAMP;
    endcase
  endfunction

  function automatic logic signed [31:0] sat32(input logic signed [79:0] v);
    if (v > 80'sh7FFF_FFFF) begin
      sat32 = 32'sh7FFF_FFFF;
    end else if (v < -80'sh8000_0000) begin
      sat32 = 32'sh8000_0000;
    end else begin
      sat32 = v[31:0];
    end
  endfunction

  function automatic logic signed [79:0] wide(input logic [32:0] c);
    wide = $signed({47'd0, c});
  endfunction

  function automatic logic signed [79:0] loop_err(input logic signed [79:0] x,
                                                  input logic signed [79:0] y,
                                                  input logic signed [79:0] z,
                                                  input logic [32:0]        d2);
    loop_err = x - y - ((wide(d2) * z) >>> 16);
  endfunction

  function automatic logic [32:0] sat_coef(input logic [39:0] q, input logic [32:0] hi);
    sat_coef = (q > 40'(hi)) ? hi : q[32:0];
  endfunction

  function automatic logic below_half(input logic [31:0] f);
    below_half = (f < F_LIMIT);
  endfunction

  function automatic logic stage_active(input ssf_stage_cfg_t c);
    stage_active = c.enable && ((c.kind == `SSF_TYPE_PT1) ? (c.k1 != 33'd0) : c.so_ok);
  endfunction

  function automatic int stage_idx(input logic stage, input int base);
    stage_idx = base + (stage ? 6 : 0);
  endfunction

  // One sample through one stage; any bypass case tracks the input so that
  // switching the stage on later starts without a jump.
  function automatic ssf_step_t stage_step(input ssf_stage_cfg_t c, input ssf_state_t s,
                                           input logic signed [31:0] x);
    logic signed [79:0] xw;
    logic signed [79:0] yw;
    logic signed [79:0] zw;
    logic signed [79:0] e;
    logic signed [79:0] o;
    ssf_step_t          r;
    xw = 80'(x);
    yw = 80'(s.y);
    zw = 80'(s.z);
    r.st.y = x;
    r.st.z = 32'sh0000_0000;
    r.out  = x;
    if (c.enable) begin
      if (c.kind == `SSF_TYPE_PT1) begin
        if (c.k1 != 33'd0) begin
          r.st.y = sat32(yw + (((xw - yw) * wide(c.k1)) >>> 16));
          r.st.z = 32'sh0000_0000;
          r.out  = r.st.y;
        end
      end else if (c.so_ok) begin
        e      = loop_err(xw, yw, zw, c.d2);
        r.st.z = sat32(zw + ((wide(c.a) * e) >>> 16));
        zw     = 80'(r.st.z);
        r.st.y = sat32(yw + ((wide(c.a) * zw) >>> 16));
        yw     = 80'(r.st.y);
        r.out  = r.st.y;
        if (c.kind == `SSF_TYPE_GEN) begin
          e     = loop_err(xw, yw, zw, c.d2);
          o     = yw + ((wide(c.n1) * zw) >>> 16) + ((wide(c.n2) * e) >>> 16);
          r.out = sat32(o);
        end
      end
    end
    stage_step = r;
  endfunction

  // ----------------------------------------------------------------------
  // Register file and APB slave
  // ----------------------------------------------------------------------
  logic [31:0]    cfg_reg [0:`SSF_NUM_CFG-1];
  logic [31:0]    prdata_reg;
  logic           dirty_reg;
  logic [3:0]     idx;
  logic           mapped;
  logic           is_status;
  logic           wr_en;
  logic [31:0]    status;
  ssf_div_state_t div_state_reg;
  logic [1:0]     job_reg;
  logic [5:0]     bit_cnt_reg;
  logic [39:0]    num_reg;
  logic [39:0]    den_reg;
  logic [40:0]    rem_reg;
  logic [39:0]    quo_reg;
  logic [32:0]    k1_reg [0:1];
  logic [32:0]    ratio_reg [0:1];
  ssf_stage_cfg_t cfg [0:1];
  ssf_state_t     st_reg [0:1];
  ssf_step_t      step1;
  ssf_step_t      step2;
  logic           mid_valid_reg;
  logic signed [31:0] mid_data_reg;

  assign idx       = PADDR[5:2];
  assign is_status = (PADDR == `SSF_OFF_STATUS);
  assign mapped    = (PADDR[1:0] == 2'b00) && ((PADDR <= `SSF_OFF_S2_DNUM) || is_status);
  assign wr_en     = PSEL && PENABLE && PWRITE && mapped && !is_status;
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL && PENABLE && !mapped;
  assign PRDATA    = prdata_reg;
  assign status    = {29'd0, (div_state_reg != DIV_IDLE) || dirty_reg,
                      stage_active(cfg[1]), stage_active(cfg[0])};

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      for (int i = 0; i < `SSF_NUM_CFG; i++) begin
        cfg_reg[i] <= reset_value(4'(i));
      end
    end else if (wr_en) begin
      cfg_reg[idx] <= limit_write(idx, PWDATA);
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      prdata_reg <= 32'h0000_0000;
    end else if (PSEL && !PENABLE) begin
      if (!mapped) begin
        prdata_reg <= 32'h0000_0000;
      end else if (is_status) begin
        prdata_reg <= status;
      end else begin
        prdata_reg <= cfg_reg[idx];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Coefficient divider
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      dirty_reg <= 1'b1;
    end else if (wr_en) begin
      dirty_reg <= 1'b1;
    end else if (div_state_reg == DIV_IDLE) begin
      dirty_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      div_state_reg <= DIV_IDLE;
      job_reg       <= 2'd0;
      bit_cnt_reg   <= 6'd0;
      num_reg       <= 40'd0;
      den_reg       <= 40'd0;
      rem_reg       <= 41'd0;
      quo_reg       <= 40'd0;
    end else begin
      unique case (div_state_reg)
        DIV_IDLE: begin
          if (dirty_reg) begin
            job_reg       <= 2'd0;
            div_state_reg <= DIV_LOAD;
          end
        end
        DIV_LOAD: begin
          if (!job_reg[0]) begin
            num_reg <= K1_NUM[39:0];
            den_reg <= {8'd0, cfg_reg[stage_idx(job_reg[1], 2)]};
          end else begin
            num_reg <= {6'd0, cfg_reg[stage_idx(job_reg[1], 3)][17:0], 16'd0};
            den_reg <= {8'd0, cfg_reg[stage_idx(job_reg[1], 5)]};
          end
          rem_reg       <= 41'd0;
          quo_reg       <= 40'd0;
          bit_cnt_reg   <= `SSF_DIV_BITS;
          div_state_reg <= DIV_RUN;
        end
        DIV_RUN: begin
          if ({rem_reg[39:0], num_reg[39]} >= {1'b0, den_reg}) begin
            rem_reg <= {rem_reg[39:0], num_reg[39]} - {1'b0, den_reg};
            quo_reg <= {quo_reg[38:0], 1'b1};
          end else begin
            rem_reg <= {rem_reg[39:0], num_reg[39]};
            quo_reg <= {quo_reg[38:0], 1'b0};
          end
          num_reg     <= {num_reg[38:0], 1'b0};
          bit_cnt_reg <= bit_cnt_reg - 6'd1;
          if (bit_cnt_reg == 6'd1) begin
            div_state_reg <= DIV_STORE;
          end
        end
        DIV_STORE: begin
          job_reg       <= job_reg + 2'd1;
          div_state_reg <= (job_reg == 2'd3) ? DIV_IDLE : DIV_LOAD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Coefficient store
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      k1_reg[0]    <= 33'd0;
      k1_reg[1]    <= 33'd0;
      ratio_reg[0] <= `SSF_K1_MAX;
      ratio_reg[1] <= `SSF_K1_MAX;
    end else if (div_state_reg == DIV_STORE) begin
      if (!job_reg[0]) begin
        // zero time constant gives zero gain
        k1_reg[job_reg[1]] <= (den_reg == 40'd0) ? 33'd0 : sat_coef(quo_reg, `SSF_K1_MAX);
      end else begin
        ratio_reg[job_reg[1]] <= sat_coef(quo_reg, `SSF_RATIO_MAX);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Stage configuration
  // ----------------------------------------------------------------------
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      logic [63:0] d2w;
      logic [63:0] dnw;
      logic [63:0] n1w;
      logic [65:0] n2w;
      int          b;
      b   = 6 * s;
      d2w = (64'(cfg_reg[b + 4]) * `SSF_DAMP2_MUL) >> 10;
      dnw = (64'(cfg_reg[b + 6]) * `SSF_DAMP2_MUL) >> 10;
      n1w = (dnw * 64'(ratio_reg[s])) >> 16;
      n2w = (66'(ratio_reg[s]) * 66'(ratio_reg[s])) >> 16;
      cfg[s].enable = cfg_reg[0][s];
      cfg[s].kind   = cfg_reg[b + 1][15:0];
      cfg[s].k1     = k1_reg[s];
      cfg[s].a      = 33'((64'(cfg_reg[b + 3]) * A_MUL) >> 20);
      cfg[s].d2     = d2w[32:0];
      cfg[s].n1     = n1w[32:0];
      cfg[s].n2     = n2w[32:0];
      cfg[s].so_ok  = below_half(cfg_reg[b + 3]) &&
                      ((cfg[s].kind != `SSF_TYPE_GEN) || below_half(cfg_reg[b + 5]));
    end
  end

  // ----------------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------------
  // cascade stage one into stage two
  assign step1 = stage_step(cfg[0], st_reg[0], SP_IN_DATA);
  // stage two uses the same step
  assign step2 = stage_step(cfg[1], st_reg[1], mid_data_reg);

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_reg[0]     <= '0;
      mid_valid_reg <= 1'b0;
      mid_data_reg  <= 32'sh0000_0000;
    end else begin
      mid_valid_reg <= SP_IN_VALID;
      if (SP_IN_VALID) begin
        st_reg[0]    <= step1.st;
        mid_data_reg <= step1.out;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_reg[1]    <= '0;
      SP_OUT_VALID <= 1'b0;
      SP_OUT_DATA  <= 32'sh0000_0000;
    end else begin
      SP_OUT_VALID <= mid_valid_reg;
      if (mid_valid_reg) begin
        st_reg[1]   <= step2.st;
        SP_OUT_DATA <= step2.out;
      end
    end
  end

endmodule

/* src/ssf_regs.svh */
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SSF_OFF_ENABLE      8'h00
`define SSF_OFF_S1_TYPE     8'h04
`define SSF_OFF_S1_TC       8'h08
`define SSF_OFF_S1_FDEN     8'h0C
`define SSF_OFF_S1_DDEN     8'h10
`define SSF_OFF_S1_FNUM     8'h14
`define SSF_OFF_S1_DNUM     8'h18
`define SSF_OFF_S2_TYPE     8'h1C
`define SSF_OFF_S2_TC       8'h20
`define SSF_OFF_S2_FDEN     8'h24
`define SSF_OFF_S2_DDEN     8'h28
`define SSF_OFF_S2_FNUM     8'h2C
`define SSF_OFF_S2_DNUM     8'h30
`define SSF_OFF_STATUS      8'h34
`define SSF_NUM_CFG         13

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define SSF_EN_S1_BIT       0
`define SSF_EN_S2_BIT       1
`define SSF_TYPE_PT1        16'h0000
`define SSF_TYPE_PT2        16'h0001
`define SSF_TYPE_GEN        16'h0002

// ----------------------------------------------------------------------
// Reset values and ranges (tc in 0.01 ms, freq in 0.1 Hz, damping in 0.001)
// ----------------------------------------------------------------------
`define SSF_RST_ENABLE      32'h0000_0001
`define SSF_RST_TYPE        32'h0000_0000
`define SSF_RST_TC          32'h0000_0000
`define SSF_RST_FREQ        32'h0000_4E20
`define SSF_RST_DAMP        32'h0000_02BC
`define SSF_MAX_TYPE        32'h0000_0002
`define SSF_MAX_TC          32'h0007_A120
`define SSF_MIN_FREQ        32'h0000_0005
`define SSF_MAX_FREQ        32'h0002_7100
`define SSF_MIN_DDEN        32'h0000_0001
`define SSF_MIN_DNUM        32'h0000_0000
`define SSF_MAX_DAMP        32'h0000_2710

// ----------------------------------------------------------------------
// Timing and scaling
// ----------------------------------------------------------------------
`define SSF_SAMPLE_HZ       8000
`define SSF_TWO_PI_Q16      64'h0000_0000_0006_487F
`define SSF_TC_UNITS_PER_S  64'h0000_0000_0001_86A0
`define SSF_DAMP2_MUL       64'h0000_0000_0002_0C4A
`define SSF_RATIO_MAX       33'h0_0100_0000
`define SSF_K1_MAX          33'h0_0001_0000
`define SSF_DIV_BITS        6'h28

`endif

/* src/ssf_pkg.sv */
package ssf_pkg;

  typedef struct packed {
    logic               enable;
    logic [15:0]        kind;
    logic               so_ok;
    logic [32:0]        k1;
    logic [32:0]        a;
    logic [32:0]        d2;
    logic [32:0]        n1;
    logic [32:0]        n2;
  } ssf_stage_cfg_t;

  typedef struct packed {
    logic signed [31:0] y;
    logic signed [31:0] z;
  } ssf_state_t;

  typedef struct packed {
    ssf_state_t         st;
    logic signed [31:0] out;
  } ssf_step_t;

  typedef enum logic [1:0] {DIV_IDLE, DIV_LOAD, DIV_RUN, DIV_STORE} ssf_div_state_t;

endpackage

/* verification/ssf_top_monitor.sv */
`timescale 1ns/1ps
`include "ssf_regs.svh"
module ssf_monitor
  import ssf_pkg::*;
(
  input wire logic               SYS_CLK,
  input wire logic               RST,
  input wire logic               PSEL,
  input wire logic               PENABLE,
  input wire logic               PWRITE,
  input wire logic [7:0]         PADDR,
  input wire logic [31:0]        PWDATA,
  input wire logic [31:0]        PRDATA,
  input wire logic               PREADY,
  input wire logic               PSLVERR,
  input wire logic               SP_IN_VALID,
  input wire logic signed [31:0] SP_IN_DATA,
  input wire logic               SP_OUT_VALID,
  input wire logic signed [31:0] SP_OUT_DATA
);
  logic [31:0] shd_reg [0:12];
  logic        rd;

  function automatic logic [31:0] lim(input logic [3:0] i, input logic [31:0] v);
    case (i)
      4'h0: lim = v & 32'h0000_0003;
      4'h1, 4'h7: lim = (v > `SSF_MAX_TYPE) ? `SSF_MAX_TYPE : v;
      4'h2: lim = (v > `SSF_MAX_TC) ? `SSF_MAX_TC : v;
      4'h3: lim = (v < `SSF_MIN_FREQ) ? `SSF_MIN_FREQ : ((v > `SSF_MAX_FREQ) ? `SSF_MAX_FREQ : v);
      default: lim = v;
    endcase
  endfunction

  assign rd = PSEL && PENABLE && !PWRITE;

  // Shadow copy of the settings that software has written.
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      for (int i = 0; i < 13; i++) shd_reg[i] <= 32'h0000_0000;
      shd_reg[0] <= `SSF_RST_ENABLE;
      shd_reg[3] <= `SSF_RST_FREQ;
    end else if (PSEL && PENABLE && PWRITE && PADDR[1:0] == 2'h0 && PADDR < `SSF_OFF_STATUS) begin
      shd_reg[PADDR[5:2]] <= lim(PADDR[5:2], PWDATA);
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  a_out_two_cycles: assert property (SP_IN_VALID |-> ##2 SP_OUT_VALID)
    else $error("Output sample late or missing.");
  a_out_has_cause: assert property (SP_OUT_VALID |-> $past(SP_IN_VALID, 2))
    else $error("Output sample without input.");
  a_out_data_held: assert property (!SP_OUT_VALID |-> $stable(SP_OUT_DATA))
    else $error("Output data changed between samples.");
  a_both_off_pass: assert property (SP_IN_VALID && shd_reg[0][1:0] == 2'h0
    |-> ##2 SP_OUT_DATA == $past(SP_IN_DATA, 2)) else $error("Disabled stages altered data.");
  a_enable_read: assert property (rd && PADDR == `SSF_OFF_ENABLE |-> PRDATA == shd_reg[0])
    else $error("Enable word read wrong.");
  a_type1_read: assert property (rd && PADDR == `SSF_OFF_S1_TYPE |-> PRDATA == shd_reg[1])
    else $error("Stage one type read wrong.");
  a_type2_read: assert property (rd && PADDR == `SSF_OFF_S2_TYPE |-> PRDATA == shd_reg[7])
    else $error("Stage two type read wrong.");
  a_tc1_read: assert property (rd && PADDR == `SSF_OFF_S1_TC |-> PRDATA == shd_reg[2])
    else $error("Stage one time constant read wrong.");
  a_fden1_read: assert property (rd && PADDR == `SSF_OFF_S1_FDEN |-> PRDATA == shd_reg[3])
    else $error("Stage one frequency read wrong.");
endmodule

bind ssf_top ssf_monitor i_ssf_monitor (
  .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SP_IN_VALID(SP_IN_VALID), .SP_IN_DATA(SP_IN_DATA), .SP_OUT_VALID(SP_OUT_VALID),
  .SP_OUT_DATA(SP_OUT_DATA)
);

/* verification/ssf_sp_partner.sv */
`timescale 1ns/1ps
module ssf_sp_partner (
  input  wire logic               clk,
  input  wire logic               out_valid,
  output logic                    in_valid,
  output logic signed [31:0]      in_data,
  output int                      n_taken
);
  initial begin
    in_valid = 1'b0;
    in_data = 32'h0000_0000;
    n_taken = 0;
  end

  // Downstream side counts every filtered sample it takes.
  always @(negedge clk) begin
    if (out_valid === 1'b1) n_taken = n_taken + 1;
  end

  // Source side sends samples back to back, then drops valid and inverts the data lines.
  task automatic burst(input logic [31:0] xs [$]);
    foreach (xs[i]) begin
      @(posedge clk);
      in_valid <= 1'b1;
      in_data <= xs[i];
    end
    @(posedge clk);
    in_valid <= 1'b0;
    in_data <= ~in_data;
  endtask
endmodule

/* verification/test_speed_setpoint_filter_pair.sv */
`timescale 1ns/1ps
`include "ssf_regs.svh"
module test_speed_setpoint_filter_pair import ssf_pkg::*;;
  logic               SYS_CLK;
  logic               RST;
  logic               PSEL;
  logic               PENABLE;
  logic               PWRITE;
  logic [7:0]         PADDR;
  logic [31:0]        PWDATA;
  logic [31:0]        PRDATA;
  logic               PREADY;
  logic               PSLVERR;
  logic               SP_IN_VALID;
  logic signed [31:0] SP_IN_DATA;
  logic               SP_OUT_VALID;
  logic signed [31:0] SP_OUT_DATA;
  logic [31:0]        rdata;
  logic [31:0]        seed;
  logic [31:0]        e;
  logic               err;
  logic [31:0]        exp_q [$];
  logic [31:0]        xs [$];
  logic [31:0]        vals [3];
  logic [31:0]        lo6 [6] = '{32'h0, 32'h0, `SSF_MIN_FREQ, `SSF_MIN_DDEN, `SSF_MIN_FREQ,
                                  `SSF_MIN_DNUM};
  logic [31:0]        hi6 [6] = '{`SSF_MAX_TYPE, `SSF_MAX_TC, `SSF_MAX_FREQ, `SSF_MAX_DAMP,
                                  `SSF_MAX_FREQ, `SSF_MAX_DAMP};
  logic [31:0]        rs6 [6] = '{`SSF_RST_TYPE, `SSF_RST_TC, `SSF_RST_FREQ, `SSF_RST_DAMP,
                                  `SSF_RST_FREQ, `SSF_RST_DAMP};
  int                 n_fail = 0;
  int                 samples_checked = 0;
  int                 n_sent = 0;
  int                 n_taken;
  int                 cyc = 0;

  ssf_top i_ssf_top (
    .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SP_IN_VALID(SP_IN_VALID), .SP_IN_DATA(SP_IN_DATA), .SP_OUT_VALID(SP_OUT_VALID),
    .SP_OUT_DATA(SP_OUT_DATA));
  ssf_sp_partner i_ssf_sp_partner (.clk(SYS_CLK), .out_valid(SP_OUT_VALID),
    .in_valid(SP_IN_VALID), .in_data(SP_IN_DATA), .n_taken(n_taken));

  initial begin
    SYS_CLK = 1'b0;
    forever #4 SYS_CLK = ~SYS_CLK;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'hA300_0000) : (s >> 1);
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge SYS_CLK);
    end while (PREADY !== 1'b1);
    rdata = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(what, exp, rdata);
  endtask

  task automatic stream(input int n);
    xs.delete();
    repeat (n) begin
      seed = lfsr(seed);
      xs.push_back(seed);
      exp_q.push_back(seed);
      n_sent++;
    end
    i_ssf_sp_partner.burst(xs);
    repeat (4) @(posedge SYS_CLK);
  endtask

  task automatic cfg(input logic [31:0] en, t1, tc1, fd1, fn1, t2, tc2,
                     input logic [1:0] st, input int n);
    int k;
    apb(1'b1, `SSF_OFF_S1_TYPE, t1);
    apb(1'b1, `SSF_OFF_S1_TC, tc1);
    apb(1'b1, `SSF_OFF_S1_FDEN, fd1);
    apb(1'b1, `SSF_OFF_S1_FNUM, fn1);
    apb(1'b1, `SSF_OFF_S2_TYPE, t2);
    apb(1'b1, `SSF_OFF_S2_TC, tc2);
    apb(1'b1, `SSF_OFF_ENABLE, en);
    rd_chk(`SSF_OFF_ENABLE, en & 32'h3, "enable word");
    k = 0;
    do begin
      apb(1'b0, `SSF_OFF_STATUS, 32'h0);
      k++;
    end while (rdata[2] !== 1'b0 && k < 200);
    check("filter status", {30'h0, st}, {30'h0, rdata[1:0]});
    stream(n);
    $display("config test done");
  endtask

  // Every filtered sample is compared with the oldest noted expectation.
  always @(negedge SYS_CLK) begin
    if (SP_OUT_VALID === 1'b1) begin
      if (exp_q.size() == 0) check("spare output", 32'h0, 32'h1);
      else check("output sample", exp_q.pop_front(), SP_OUT_DATA);
    end
  end

  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      final_report;
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    seed = 32'h3956;
    repeat (8) @(posedge SYS_CLK);
    RST <= 1'b0;
    rd_chk(`SSF_OFF_ENABLE, `SSF_RST_ENABLE, "enable reset");
    for (int i = 1; i < 13; i++) begin
      rd_chk(8'(i * 4), rs6[(i - 1) % 6], "reset value");
    end
    $display("reset test done");
    for (int i = 1; i < 13; i++) begin
      seed = lfsr(seed);
      vals = '{32'h0, 32'hFFFF_FFFF, seed & 32'h0000_FFFF};
      foreach (vals[k]) begin
        apb(1'b1, 8'(i * 4), vals[k]);
        e = vals[k] < lo6[(i - 1) % 6] ? lo6[(i - 1) % 6] : vals[k];
        e = e > hi6[(i - 1) % 6] ? hi6[(i - 1) % 6] : e;
        rd_chk(8'(i * 4), e, "limited value");
      end
      apb(1'b1, 8'(i * 4), rs6[(i - 1) % 6]);
    end
    $display("range test done");
    apb(1'b1, 8'h02, 32'h0);
    check("misaligned error", 32'h1, {31'h0, err});
    apb(1'b0, 8'h38, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rdata);
    $display("error test done");
    cfg(32'h0, 32'h2, 32'h0, 32'h4E20, 32'h4E20, 32'h1, 32'h0, 2'h0, 8);
    cfg(32'h1, 32'h0, 32'h0, 32'h4E20, 32'h4E20, 32'h1, 32'h0, 2'h0, 8);
    repeat (3) stream(1);
    cfg(32'h3, 32'h0, 32'h0, 32'h4E20, 32'h4E20, 32'h0, 32'h0, 2'h0, 8);
    cfg(32'h1, 32'h1, 32'h0, 32'h9C40, 32'h5, 32'h0, 32'h0, 2'h0, 8);
    cfg(32'h1, 32'h2, 32'h0, 32'h9C36, 32'h9C40, 32'h0, 32'h0, 2'h0, 8);
    cfg(32'h1, 32'h1, 32'h0, 32'h9C36, 32'h9C40, 32'h0, 32'h0, 2'h1, 0);
    cfg(32'h1, 32'h2, 32'h0, 32'h9C36, 32'h9C36, 32'h0, 32'h0, 2'h1, 0);
    cfg(32'h3, 32'h0, 32'h3E8, 32'h4E20, 32'h4E20, 32'h0, 32'h3E8, 2'h3, 0);
    cfg(32'h2, 32'h0, 32'h3E8, 32'h4E20, 32'h4E20, 32'h1, 32'h0, 2'h2, 0);
    check("output count", 32'(n_sent), 32'(n_taken));
    final_report;
  end
endmodule
